//--- lss_pkg.sv
// Shared constants and types of the LIN sync and status block.
// Assumes a 40 MHz system clock and a 32-bit register port.
package lss_pkg;

	// Register byte addresses
	localparam logic [31:0] ADDR_STATUS = 32'hffff_0780;
	localparam logic [31:0] ADDR_CTRL = 32'hffff_0784;
	localparam logic [31:0] ADDR_ESEL = 32'hffff_0788;
	localparam logic [31:0] ADDR_SYNC_TMR = 32'hffff_078c;
	localparam logic [31:0] ADDR_BRK_TMR = 32'hffff_0790;
	localparam logic [31:0] ADDR_SYNC_CMP = 32'hffff_0794;
	localparam logic [31:0] ADDR_BRK_CMP = 32'hffff_0798;
	localparam logic [31:0] ADDR_MASK = 32'hffff_079c;

	// Status bit positions
	localparam int ST_BRK_VALID = 0;
	localparam int ST_START = 1;
	localparam int ST_STOP = 2;
	localparam int ST_CMP = 3;
	localparam int ST_BRK_ERR = 4;
	localparam int ST_SRST_DONE = 5;
	localparam int ST_RISE = 6;

	// Control register bit positions
	localparam int CTL_SYNC_EN = 0;
	localparam int CTL_SRST = 1;
	localparam int CTL_ALT_MODE = 2;
	localparam int CTL_BRK_EN = 3;
	localparam int CTL_RISE_GATE = 12;

	// Edge select register fields
	localparam int ESEL_START_POL = 0;
	localparam int ESEL_STOP_POL = 1;
	localparam int ESEL_CNT_LSB = 4;
	localparam int ESEL_CNT_W = 4;

	// Reset values and the break timer limit
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [6:0] MASK_RST = 7'h00;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [15:0] ESEL_RST = 16'h0040;
	localparam logic [15:0] SYNC_CMP_RST = 16'hffff;
	localparam logic [11:0] BRK_CMP_RST = 12'h010;
	localparam logic [11:0] BRK_TMR_MAX = 12'hfff;

	// Soft reset of the sync logic takes this many system clocks
	localparam logic [2:0] SRST_CYCLES = 3'h4;

	// One bit per status event
	typedef struct packed {
		logic rise;
		logic srst_done;
		logic brk_err;
		logic cmp;
		logic stop;
		logic start;
		logic brk_valid;
	} lss_evt_s;

	typedef enum logic [1:0] {
		SYNC_IDLE,
		SYNC_ARMED,
		SYNC_COUNT,
		SYNC_DONE
	} lss_sync_e;

endpackage : lss_pkg

//--- lss_sync3.sv
// Two-stage synchronisers for three asynchronous inputs.
// Assumes an active-low reset already local to clk.
`timescale 1ns/100ps
`default_nettype none
module lss_sync3 (
	input wire logic clk, // System clock
	input wire logic rst_n, // Synchronous-release reset
	input wire logic [2:0] d, // Asynchronous inputs
	output logic [2:0] q // Synchronised copies
);
	logic [2:0] meta;

	genvar i;
	generate
		for (i = 0; i < 3; i++) begin : g_bit
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					meta[i] <= 1'b1;
					q[i] <= 1'b1;
				end else begin
					meta[i] <= d[i];
					q[i] <= meta[i];
				end
			end
		end
	endgenerate
endmodule : lss_sync3
`default_nettype wire

//--- lss_top.sv
// LIN slave hardware sync unit: break timer, sync byte timer, status flags.
// Assumes the bus level, low power oscillator and 5 MHz PLL clock arrive
// as asynchronous pins; a plain strobe register port on sys_clk.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
//
// Contract
// R1: Slave only; never drives the bus; timing fits 1 to 20 kBaud.
// R2: Break timer counts low power oscillator ticks, not core clock.
// R3: Sync byte timer counts ticks of the 5 MHz PLL clock.
// R4: Software selects start and stop edges through the edge-select register.
// R5: Sixteen-bit sync timer run by the first control register.
// R6: Eight-bit read-only status register, reset zero, shows sync events.
// R7: Status bit 7 reserved, reads zero, writes ignored.
// R8: Alternate sensor mode only: rising bus edge sets status bit 6.
// R9: Completed software reset of sync logic sets status bit 5.
// R10: Break timer overflow sets bit 4 and raises the interrupt.
// R11: Sync timer equal to compare value sets status bit 3.
// R12: Detected stop condition sets status bit 2.
// R13: Detected start condition sets status bit 1.
// R14: Break timer reaching break compare value sets status bit 0.
// R15: Reading status clears flags 0 through 6.
// R16: Control bit 12 gates rising-edge interrupt, polarity depends on mode.
// R17: Event coinciding with status read leaves its flag set.
module lss_top (
	input wire logic sys_clk, // 40 MHz system clock
	input wire logic rstn, // Asynchronous reset, active low
	input wire logic [31:0] bus_addr, // Register byte address
	input wire logic [31:0] bus_wdata, // Register write data
	input wire logic bus_wr, // Write strobe
	input wire logic bus_rd, // Read strobe
	output logic [31:0] bus_rdata, // Read data, cycle after bus_rd
	input wire logic lin_rx, // Bus level from transceiver
	input wire logic lp_osc_clk, // Low power oscillator pin
	input wire logic pll_5m_clk, // 5 MHz clock from the PLL
	output logic sync_irq // Interrupt, active high level
);
	logic rst_meta;
	logic rst_n;
	logic [2:0] pin_s;
	logic rx_d;
	logic lp_d;
	logic pll_d;

	logic [7:0] status;
	logic [6:0] mask;
	logic [15:0] ctrl;
	logic [15:0] esel;
	logic [15:0] sync_cmp;
	logic [11:0] brk_cmp;
	logic [15:0] sync_tmr;
	logic [11:0] brk_tmr;
	logic brk_ovf_seen;
	localparam int ESEL_W_C = lss_pkg::ESEL_CNT_W;

	logic [2:0] srst_cnt;
	logic [ESEL_W_C-1:0] edges_left;
	lss_pkg::lss_sync_e sync_st;

	// Reset release through two flops
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	lss_sync3 u_sync (
		.clk(sys_clk),
		.rst_n(rst_n),
		.d({pll_5m_clk, lp_osc_clk, lin_rx}),
		.q(pin_s)
	);

	wire rx_s = pin_s[0];
	wire lp_s = pin_s[1];
	wire pll_s = pin_s[2];

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_d <= 1'b1;
			lp_d <= 1'b1;
			pll_d <= 1'b1;
		end else begin
			rx_d <= rx_s;
			lp_d <= lp_s;
			pll_d <= pll_s;
		end
	end

	// Oscillators are sampled, so each rising edge becomes one tick
	wire lp_tick = lp_s & ~lp_d; // R2
	wire pll_tick = pll_s & ~pll_d; // R3
	wire rx_rise = rx_s & ~rx_d;
	wire rx_fall = ~rx_s & rx_d;

	// Polarity 1 selects the rising edge, 0 the falling edge
	function automatic logic edge_hit(input logic pol, input logic rise,
			input logic fall);
		edge_hit = pol ? rise : fall;
	endfunction : edge_hit

	// Register decode
	wire sel_status = bus_addr == lss_pkg::ADDR_STATUS;
	wire sel_ctrl = bus_addr == lss_pkg::ADDR_CTRL;
	wire sel_esel = bus_addr == lss_pkg::ADDR_ESEL;
	wire sel_sync_tmr = bus_addr == lss_pkg::ADDR_SYNC_TMR;
	wire sel_brk_tmr = bus_addr == lss_pkg::ADDR_BRK_TMR;
	wire sel_sync_cmp = bus_addr == lss_pkg::ADDR_SYNC_CMP;
	wire sel_brk_cmp = bus_addr == lss_pkg::ADDR_BRK_CMP;
	wire sel_mask = bus_addr == lss_pkg::ADDR_MASK;

	wire wr_ctrl = bus_wr & sel_ctrl;
	wire rd_status = bus_rd & sel_status;

	// Soft reset request: the strobe bit itself is not stored
	wire srst_req = wr_ctrl & bus_wdata[lss_pkg::CTL_SRST];
	wire srst_busy = srst_cnt != 3'h0;
	wire srst_last = srst_cnt == 3'h1;

	wire sync_en = ctrl[lss_pkg::CTL_SYNC_EN];
	wire brk_en = ctrl[lss_pkg::CTL_BRK_EN];
	wire alt_mode = ctrl[lss_pkg::CTL_ALT_MODE];
	wire rise_gate = ctrl[lss_pkg::CTL_RISE_GATE];

	wire start_hit = edge_hit(esel[lss_pkg::ESEL_START_POL],
		rx_rise, rx_fall); // R4
	wire stop_hit = edge_hit(esel[lss_pkg::ESEL_STOP_POL],
		rx_rise, rx_fall); // R4
	wire [ESEL_W_C-1:0] stop_count =
		esel[lss_pkg::ESEL_CNT_LSB +: ESEL_W_C];

	// Break timer: runs only while the bus is held low
	wire brk_run = brk_en & ~rx_s & ~srst_busy;
	wire brk_at_max = brk_tmr == lss_pkg::BRK_TMR_MAX;
	wire [11:0] brk_inc = brk_tmr + 12'h001;
	wire brk_step = brk_run & lp_tick & ~brk_at_max;
	wire brk_valid_ev = brk_step & (brk_inc == brk_cmp); // R14
	// Saturate instead of wrapping so a stuck bus does not refire a break
	wire brk_err_ev = brk_run & lp_tick & brk_at_max & ~brk_ovf_seen; // R10

	// Sync byte state machine
	wire counting = sync_st == lss_pkg::SYNC_COUNT;
	wire armed = sync_st == lss_pkg::SYNC_ARMED;
	wire start_ev = sync_en & armed & start_hit & ~srst_busy; // R13
	wire stop_edge = sync_en & counting & stop_hit & ~srst_busy;
	wire stop_ev = stop_edge & (edges_left <= 4'h1); // R12
	wire [15:0] sync_inc = sync_tmr + 16'h0001;
	wire sync_step = sync_en & counting & pll_tick & ~srst_busy; // R5
	wire cmp_ev = sync_step & (sync_inc == sync_cmp); // R11

	wire rise_ev = alt_mode & rx_rise; // R8
	// Gate bit is a disable in alternate mode, an enable in LIN mode
	wire rise_irq_en = alt_mode ? ~rise_gate : rise_gate; // R16

	lss_pkg::lss_evt_s evt;
	assign evt.rise = rise_ev;
	assign evt.srst_done = srst_last; // R9
	assign evt.brk_err = brk_err_ev;
	assign evt.cmp = cmp_ev;
	assign evt.stop = stop_ev;
	assign evt.start = start_ev;
	assign evt.brk_valid = brk_valid_ev;

	// Clear on read, then set wins over the clear
	wire [6:0] kept = rd_status ? 7'h00 : status[6:0]; // R15
	wire [7:0] next_status = {1'b0, kept | evt}; // R7 R17

	// Break error always reaches the pin; others follow the mask
	wire [6:0] irq_gate = {rise_irq_en, 1'b1, 1'b1, 4'hf};
	wire [6:0] irq_mask = mask | (7'h01 << lss_pkg::ST_BRK_ERR);
	wire next_irq = |(status[6:0] & irq_mask & irq_gate); // R10 R16

	wire [15:0] ctrl_rd = {ctrl[15:2], srst_busy, ctrl[0]};
	wire [31:0] rd_mux =
		sel_status ? {24'h00_0000, status} : // R6
		sel_ctrl ? {16'h0000, ctrl_rd} :
		sel_esel ? {16'h0000, esel} :
		sel_sync_tmr ? {16'h0000, sync_tmr} :
		sel_brk_tmr ? {20'h0_0000, brk_tmr} :
		sel_sync_cmp ? {16'h0000, sync_cmp} :
		sel_brk_cmp ? {20'h0_0000, brk_cmp} :
		sel_mask ? {25'h000_0000, mask} :
		32'h0000_0000;

	// Status has no write path at all
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			status <= lss_pkg::STATUS_RST; // R6
		end else begin
			status <= next_status;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_rdata <= 32'h0000_0000;
			sync_irq <= 1'b0;
		end else begin
			bus_rdata <= bus_rd ? rd_mux : 32'h0000_0000;
			sync_irq <= next_irq;
		end
	end

	// Software registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= lss_pkg::CTRL_RST;
			esel <= lss_pkg::ESEL_RST;
			sync_cmp <= lss_pkg::SYNC_CMP_RST;
			brk_cmp <= lss_pkg::BRK_CMP_RST;
			mask <= lss_pkg::MASK_RST;
		end else if (bus_wr) begin
			if (sel_ctrl) begin
				ctrl <= {bus_wdata[15:2], 1'b0, bus_wdata[0]};
			end
			if (sel_esel) begin
				esel <= bus_wdata[15:0];
			end
			if (sel_sync_cmp) begin
				sync_cmp <= bus_wdata[15:0];
			end
			if (sel_brk_cmp) begin
				brk_cmp <= bus_wdata[11:0];
			end
			if (sel_mask) begin
				mask <= bus_wdata[6:0];
			end
		end
	end

	// Soft reset sequencer
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			srst_cnt <= 3'h0;
		end else if (srst_req) begin
			srst_cnt <= lss_pkg::SRST_CYCLES;
		end else if (srst_busy) begin
			srst_cnt <= srst_cnt - 3'h1;
		end
	end

	// Break timer
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			brk_tmr <= 12'h000;
			brk_ovf_seen <= 1'b0;
		end else if (!brk_run) begin
			brk_tmr <= 12'h000;
			brk_ovf_seen <= 1'b0;
		end else if (brk_step) begin
			brk_tmr <= brk_inc; // R2
		end else if (brk_err_ev) begin
			brk_ovf_seen <= 1'b1;
		end
	end

	// Sync timer and edge counting; the node only listens to the bus
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_st <= lss_pkg::SYNC_IDLE;
			sync_tmr <= 16'h0000;
			edges_left <= 4'h0;
		end else if (srst_busy || !sync_en) begin
			sync_st <= lss_pkg::SYNC_IDLE;
			if (srst_busy) begin
				sync_tmr <= 16'h0000;
			end
		end else if (brk_valid_ev) begin
			sync_st <= lss_pkg::SYNC_ARMED; // R1
		end else begin
			unique case (sync_st)
				lss_pkg::SYNC_IDLE: begin
					sync_st <= lss_pkg::SYNC_IDLE;
				end
				lss_pkg::SYNC_ARMED: begin
					if (start_ev) begin
						sync_st <= lss_pkg::SYNC_COUNT;
						sync_tmr <= 16'h0000;
						edges_left <= stop_count;
					end
				end
				lss_pkg::SYNC_COUNT: begin
					if (stop_ev) begin
						sync_st <= lss_pkg::SYNC_DONE;
					end else if (stop_edge) begin
						edges_left <= edges_left - 4'h1;
					end
					if (sync_step) begin
						sync_tmr <= sync_inc; // R3
					end
				end
				lss_pkg::SYNC_DONE: begin
					sync_st <= lss_pkg::SYNC_DONE;
				end
			endcase
		end
	end
endmodule : lss_top
`default_nettype wire

//--- lss_monitor.sv
// Port checker for the LIN sync and status block.
// Assumes strobes never overlap; sees only the top ports.
`timescale 1ns/100ps
`default_nettype none
module lss_monitor (
	input wire logic sys_clk, // System clock
	input wire logic rstn, // Reset, active low
	input wire logic [31:0] bus_addr, // Address
	input wire logic [31:0] bus_wdata, // Write data
	input wire logic bus_wr, // Write strobe
	input wire logic bus_rd, // Read strobe
	input wire logic [31:0] bus_rdata, // Read data
	input wire logic sync_irq // Interrupt
);
	logic [15:0] cmp_sh;
	logic [11:0] brk_sh;
	// The map fills one 32-byte aligned block
	wire mapped = bus_addr[31:5] == lss_pkg::ADDR_STATUS[31:5]
		&& bus_addr[1:0] == 2'h0;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cmp_sh <= lss_pkg::SYNC_CMP_RST;
			brk_sh <= lss_pkg::BRK_CMP_RST;
		end else if (bus_wr && bus_addr == lss_pkg::ADDR_SYNC_CMP) begin
			cmp_sh <= bus_wdata[15:0];
		end else if (bus_wr && bus_addr == lss_pkg::ADDR_BRK_CMP) begin
			brk_sh <= bus_wdata[11:0];
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	sequence rd_at(logic [31:0] a);
		$past(bus_rd) && $past(bus_addr) == a;
	endsequence
	idle_rdata_a:
	assert property (!$past(bus_rd) |-> bus_rdata == 32'h0000_0000)
		else $error("Read data not zero outside an answer");
	status_width_a:
	assert property (rd_at(lss_pkg::ADDR_STATUS) |-> bus_rdata[31:7] == 0)
		else $error("Status read shows bits above six");
	unmapped_read_a:
	assert property ($past(bus_rd) && !$past(mapped) |-> bus_rdata == 0)
		else $error("Unmapped read not zero");
	sync_cmp_keep_a:
	assert property (rd_at(lss_pkg::ADDR_SYNC_CMP)
		|-> bus_rdata == {16'h0000, cmp_sh})
		else $error("Sync compare value lost");
	brk_cmp_keep_a:
	assert property (rd_at(lss_pkg::ADDR_BRK_CMP)
		|-> bus_rdata == {20'h0_0000, brk_sh})
		else $error("Break compare value lost");
	sync_tmr_width_a:
	assert property (rd_at(lss_pkg::ADDR_SYNC_TMR) |-> bus_rdata[31:16] == 0)
		else $error("Sync timer wider than sixteen bits");
	brk_tmr_width_a:
	assert property (rd_at(lss_pkg::ADDR_BRK_TMR) |-> bus_rdata[31:12] == 0)
		else $error("Break timer wider than twelve bits");
	irq_fall_cause_a:
	assert property ($fell(sync_irq) |-> $past(bus_rd || bus_wr, 2))
		else $error("Interrupt dropped without a register access");
	cover property (rd_at(lss_pkg::ADDR_STATUS) ##0 bus_rdata != 0);
	cover property ($rose(sync_irq));
	cover property (rd_at(lss_pkg::ADDR_STATUS) ##0 bus_rdata[4]);
endmodule : lss_monitor
bind lss_top lss_monitor lss_monitor_i (.sys_clk(sys_clk), .rstn(rstn),
	.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
	.bus_rd(bus_rd), .bus_rdata(bus_rdata), .sync_irq(sync_irq));
`default_nettype wire

//--- lss_lin_master.sv
// Behavioural LIN master node plus the device's two tick clocks.
// Assumes it alone drives the bus; idle level is recessive high.
`timescale 1ns/100ps
`default_nettype none
module lss_lin_master #(
	parameter int LP_HALF = 100, // Break tick half period, ns
	parameter int BIT_NS = 50000 // 20 kBaud bit time, ns
) (
	output logic lin_rx, // Bus level seen by the slave
	output logic lp_osc_clk, // Break tick clock
	output logic pll_5m_clk // 5 MHz sync tick clock
);
	initial begin
		lin_rx = 1'b1;
		lp_osc_clk = 1'b0;
		pll_5m_clk = 1'b0;
	end
	// Sped up so a break overflow fits a short run
	always #LP_HALF lp_osc_clk = ~lp_osc_clk;
	always #100 pll_5m_clk = ~pll_5m_clk;
	task automatic brk(input int ticks);
		lin_rx = 1'b0;
		repeat (ticks) @(posedge lp_osc_clk);
		#(LP_HALF);
		lin_rx = 1'b1;
		#(BIT_NS);
	endtask : brk
	task automatic sync_byte(input logic [7:0] b);
		lin_rx = 1'b0;
		#(BIT_NS);
		for (int i = 0; i < 8; i++) begin
			lin_rx = b[i];
			#(BIT_NS);
		end
		lin_rx = 1'b1;
		#(BIT_NS);
	endtask : sync_byte
endmodule : lss_lin_master
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the LIN sync and status block.
// Assumes the master model drives the bus and both tick clocks.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic sys_clk, rstn, bus_wr, bus_rd;
	// Pins come from the master model, not from the bench
	wire logic lin_rx, lp_osc_clk, pll_5m_clk;
	logic sync_irq;
	logic [31:0] bus_addr, bus_wdata, bus_rdata, q;
	int failures = 0;
	int checked = 0;
	lss_top lss_top_i (.sys_clk(sys_clk), .rstn(rstn), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_rdata(bus_rdata), .lin_rx(lin_rx), .lp_osc_clk(lp_osc_clk),
		.pll_5m_clk(pll_5m_clk), .sync_irq(sync_irq));
	lss_lin_master lss_lin_master_i (.lin_rx(lin_rx),
		.lp_osc_clk(lp_osc_clk), .pll_5m_clk(pll_5m_clk));
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	task automatic final_report;
		if (failures == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : final_report
	task automatic chk(input string w, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s: expected %h seen %h", w, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [31:0] a, d);
		@(posedge sys_clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge sys_clk);
		bus_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge sys_clk);
		bus_rd <= 1'b0;
		#1 d = bus_rdata;
	endtask : rd
	task automatic rc(input string w, input logic [31:0] a, exp);
		logic [31:0] d;
		rd(a, d);
		chk(w, d, exp);
	endtask : rc
	task automatic irq(input string w, input logic e);
		repeat (2) @(posedge sys_clk);
		#1 chk(w, 32'(sync_irq), 32'(e));
	endtask : irq
	initial begin
		// About two milliseconds of bus traffic, with margin
		#2_400_000;
		failures++;
		final_report;
	end
	initial begin
		rstn = 1'b0;
		bus_addr = 0;
		bus_wdata = 0;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rc("status", lss_pkg::ADDR_STATUS, 32'h0000_0000);
		rc("sync cmp", lss_pkg::ADDR_SYNC_CMP, 32'h0000_ffff);
		rc("brk cmp", lss_pkg::ADDR_BRK_CMP, 32'h0000_0010);
		rc("edge sel", lss_pkg::ADDR_ESEL, 32'h0000_0040);
		rc("unmapped", 32'hffff_07a0, 32'h0000_0000);
		wr(lss_pkg::ADDR_STATUS, 32'h0000_00ff);
		rc("status wr", lss_pkg::ADDR_STATUS, 32'h0000_0000);
		// Break compare above one bit time so data bits never re-arm
		wr(lss_pkg::ADDR_BRK_CMP, 32'h0000_0200);
		wr(lss_pkg::ADDR_SYNC_CMP, 32'h0000_0064);
		wr(lss_pkg::ADDR_MASK, 32'h0000_007f);
		wr(lss_pkg::ADDR_CTRL, 32'h0000_0009);
		lss_lin_master_i.brk(600);
		lss_lin_master_i.sync_byte(8'h55);
		irq("frame irq", 1'b1);
		rc("frame", lss_pkg::ADDR_STATUS, 32'h0000_000f);
		irq("irq cleared", 1'b0);
		rc("cleared", lss_pkg::ADDR_STATUS, 32'h0000_0000);
		// Eight bit times from first to fifth falling edge at 5 MHz
		rd(lss_pkg::ADDR_SYNC_TMR, q);
		chk("sync tmr", 32'(q > 1995 && q < 2005), 32'h1);
		// Rising start and stop, one stop edge: break end to pulse end
		wr(lss_pkg::ADDR_ESEL, 32'h0000_0013);
		lss_lin_master_i.brk(600);
		lss_lin_master_i.brk(2);
		rc("rise frame", lss_pkg::ADDR_STATUS, 32'h0000_000f);
		rd(lss_pkg::ADDR_SYNC_TMR, q);
		chk("rise tmr", 32'(q > 247 && q < 257), 32'h1);
		wr(lss_pkg::ADDR_MASK, 32'h0000_0000);
		wr(lss_pkg::ADDR_CTRL, 32'h0000_0008);
		lss_lin_master_i.brk(4200);
		irq("brk err irq", 1'b1);
		rc("brk err", lss_pkg::ADDR_STATUS, 32'h0000_0011);
		wr(lss_pkg::ADDR_MASK, 32'h0000_0040);
		wr(lss_pkg::ADDR_CTRL, 32'h0000_0004);
		lss_lin_master_i.brk(2);
		irq("alt irq", 1'b1);
		rc("rise", lss_pkg::ADDR_STATUS, 32'h0000_0040);
		wr(lss_pkg::ADDR_CTRL, 32'h0000_1004);
		lss_lin_master_i.brk(2);
		irq("alt gated", 1'b0);
		rc("rise gated", lss_pkg::ADDR_STATUS, 32'h0000_0040);
		wr(lss_pkg::ADDR_CTRL, 32'h0000_1000);
		lss_lin_master_i.brk(2);
		irq("lin irq", 1'b0);
		rc("lin rise", lss_pkg::ADDR_STATUS, 32'h0000_0000);
		wr(lss_pkg::ADDR_CTRL, 32'h0000_0002);
		// Read is taken in the cycle that sets the reset-done flag
		repeat (2) @(posedge sys_clk);
		rc("srst race", lss_pkg::ADDR_STATUS, 32'h0000_0000);
		rc("srst done", lss_pkg::ADDR_STATUS, 32'h0000_0020);
		final_report;
	end
endmodule : tb_top
`default_nettype wire
